// ---- hdl/lsbx_defs.svh ----
`ifndef LSBX_DEFS_SVH
`define LSBX_DEFS_SVH

// Register byte offsets
`define LSBX_OFF_CMD 8'h00
`define LSBX_OFF_ARG 8'h04
`define LSBX_OFF_STAT 8'h08
`define LSBX_OFF_FLAGS 8'h0c
`define LSBX_OFF_EXT 8'h10
`define LSBX_OFF_SP 8'h14
`define LSBX_GPR_WINDOW_BIT 7

// Command word fields
`define LSBX_CMD_OP_LSB 0
`define LSBX_CMD_MODE_LSB 8
`define LSBX_CMD_PTR_LSB 12
`define LSBX_CMD_NOOPND_BIT 15
`define LSBX_CMD_RD_LSB 16
`define LSBX_CMD_SRC_LSB 24
`define LSBX_CMD_BIT_LSB 29

// Status word fields
`define LSBX_STAT_BUSY_BIT 0
`define LSBX_STAT_CYC_LSB 8

// Flag positions in the status_flags_register
`define LSBX_FLAG_C 0
`define LSBX_FLAG_Z 1
`define LSBX_FLAG_N 2
`define LSBX_FLAG_V 3
`define LSBX_FLAG_S 4
`define LSBX_FLAG_H 5
`define LSBX_FLAG_T 6
`define LSBX_FLAG_I 7

// Reset values
`define LSBX_RST_FLAGS 8'h00
`define LSBX_RST_EXT 8'h00
`define LSBX_RST_SP 16'h00ff

// Data space regions
`define LSBX_SRAM_BASE 16'h2000
`define LSBX_EXT_BASE 16'h4000

// Cycle counts
`define LSBX_CYC_SINGLE 8'h01
`define LSBX_CYC_PREDEC 8'h02
`define LSBX_CYC_DISP 8'h02
`define LSBX_CYC_DIRECT 8'h02
`define LSBX_CYC_PROG 8'h03
`define LSBX_CYC_PROG_WRITE 8'h01
`define LSBX_CYC_POP 8'h02
`define LSBX_CYC_SRAM_EXTRA 8'h01

`endif

// ---- hdl/lsbx_pkg.sv ----
package lsbx_pkg;

	// Operations, coded by position starting at zero
	typedef enum logic [4:0] {
		OP_NOP,
		OP_INDIRECT_LOAD,
		OP_INDIRECT_WRITE,
		OP_DIRECT_DATA_WRITE,
		OP_PROGRAM_MEMORY_READ,
		OP_EXTENDED_PROGRAM_READ,
		OP_PROGRAM_MEMORY_WRITE,
		OP_IO_READ,
		OP_IO_WRITE,
		OP_PUSH,
		OP_POP,
		OP_SHIFT_LEFT_LOGICAL,
		OP_SHIFT_RIGHT_LOGICAL,
		OP_SHIFT_RIGHT_ARITH,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_FLAG_SET,
		OP_FLAG_CLEAR
	} lsbx_op_t;

	typedef enum logic [1:0] {MODE_PLAIN, MODE_POST_INC, MODE_PRE_DEC, MODE_DISP} lsbx_mode_t;

	typedef enum logic {SEQ_IDLE, SEQ_EXEC} lsbx_state_t;

endpackage

// ---- hdl/lsbx_mem_if.sv ----
interface lsbx_mem_if;
	logic [15:0] d_addr;
	logic [7:0] d_wdata;
	logic d_we;
	logic [7:0] d_rdata;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic io_we;
	logic [7:0] io_rdata;
	logic [23:0] p_addr;
	logic [15:0] p_wdata;
	logic p_we;
	logic [7:0] p_rdata;

	modport core (output d_addr, d_wdata, d_we, io_addr, io_wdata, io_we, p_addr, p_wdata, p_we,
		input d_rdata, io_rdata, p_rdata);
	modport mem (input d_addr, d_wdata, d_we, io_addr, io_wdata, io_we, p_addr, p_wdata, p_we,
		output d_rdata, io_rdata, p_rdata);
endinterface

// ---- hdl/lsbx_mem.sv ----
module lsbx_mem #(
	parameter int DDEPTH = 256,
	parameter int PDEPTH = 256
) (
	input wire logic i_clock,
	lsbx_mem_if.mem mif
);
	localparam int DW = $clog2(DDEPTH);
	localparam int PW = $clog2(PDEPTH);

	logic [7:0] dmem_r [DDEPTH];
	logic [7:0] io_r [64];
	logic [15:0] pmem_r [PDEPTH];

	// Storage updates; no reset so contents persist as in memory
	always_ff @(posedge i_clock)
	begin
		if (mif.d_we)
			dmem_r[mif.d_addr[DW-1:0]] <= mif.d_wdata;
		if (mif.io_we)
			io_r[mif.io_addr] <= mif.io_wdata;
		if (mif.p_we)
			pmem_r[mif.p_addr[PW:1]] <= mif.p_wdata;
	end

	// Reads; program word split into bytes by address bit 0
	assign mif.d_rdata = dmem_r[mif.d_addr[DW-1:0]];
	assign mif.io_rdata = io_r[mif.io_addr];
	assign mif.p_rdata = mif.p_addr[0] ? pmem_r[mif.p_addr[PW:1]][15:8] : pmem_r[mif.p_addr[PW:1]][7:0];
endmodule

// ---- hdl/lsbx_alu.sv ----
`include "lsbx_defs.svh"
module lsbx_alu (
	input wire lsbx_pkg::lsbx_op_t i_op,
	input wire logic [7:0] i_val,
	input wire logic [7:0] i_flags,
	input wire logic [2:0] i_bit,
	output logic [7:0] o_res,
	output logic [7:0] o_flags
);
	logic c_out;
	logic upd;

	// Shift, rotate and bit transfer results
	always_comb
	begin
		o_res = i_val;
		o_flags = i_flags;
		c_out = 1'b0;
		upd = 1'b0;
		case (i_op)
			lsbx_pkg::OP_SHIFT_LEFT_LOGICAL:
			begin
				o_res = {i_val[6:0], 1'b0};
				c_out = i_val[7];
				upd = 1'b1;
				o_flags[`LSBX_FLAG_H] = i_val[3];
			end
			lsbx_pkg::OP_ROTATE_LEFT_CARRY:
			begin
				o_res = {i_val[6:0], i_flags[`LSBX_FLAG_C]};
				c_out = i_val[7];
				upd = 1'b1;
				o_flags[`LSBX_FLAG_H] = i_val[3];
			end
			lsbx_pkg::OP_SHIFT_RIGHT_LOGICAL:
			begin
				o_res = {1'b0, i_val[7:1]};
				c_out = i_val[0];
				upd = 1'b1;
			end
			lsbx_pkg::OP_ROTATE_RIGHT_CARRY:
			begin
				o_res = {i_flags[`LSBX_FLAG_C], i_val[7:1]};
				c_out = i_val[0];
				upd = 1'b1;
			end
			lsbx_pkg::OP_SHIFT_RIGHT_ARITH:
			begin
				o_res = {i_val[7], i_val[7:1]};
				c_out = i_val[0];
				upd = 1'b1;
			end
			lsbx_pkg::OP_BIT_TO_TRANSFER_FLAG:
				o_flags[`LSBX_FLAG_T] = i_val[i_bit];
			lsbx_pkg::OP_TRANSFER_FLAG_TO_BIT:
				o_res[i_bit] = i_flags[`LSBX_FLAG_T];
			default:
				o_res = i_val;
		endcase
		if (upd)
		begin
			o_flags[`LSBX_FLAG_C] = c_out;
			o_flags[`LSBX_FLAG_Z] = (o_res == 8'h00);
			o_flags[`LSBX_FLAG_N] = o_res[7];
			o_flags[`LSBX_FLAG_V] = o_res[7] ^ c_out;
		end
	end
endmodule

// ---- hdl/lsbx_core.sv ----
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`include "lsbx_defs.svh"
module lsbx_core #(
	parameter int EXT_WAIT = 2,
	parameter int DDEPTH = 256,
	parameter int PDEPTH = 256
) (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_busy
);
	lsbx_mem_if mif ();

	// Bus side state
	logic wr_pend_r, rd_pend_r, hreadyout_r, hresp_r, busy_r;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r, rd_mux;
	// Architectural state
	logic [7:0] gpr_r [32];
	logic [7:0] flags_r, ext_r;
	logic [15:0] sp_r, arg_r;
	// Command execution state
	lsbx_pkg::lsbx_state_t state_r;
	logic [31:0] cmd_r;
	logic [7:0] cyc_left_r, cyc_tot_r, last_cyc_r;
	logic sram_r, xreg_r;

	wire addr_ok = i_hsel & i_hready & i_htrans[1];
	wire bus_wr = wr_pend_r;
	wire lsbx_pkg::lsbx_op_t op_r = lsbx_pkg::lsbx_op_t'(cmd_r[`LSBX_CMD_OP_LSB +: 5]);
	wire lsbx_pkg::lsbx_mode_t mode_r = lsbx_pkg::lsbx_mode_t'(cmd_r[`LSBX_CMD_MODE_LSB +: 2]);
	wire [4:0] rd_r = cmd_r[`LSBX_CMD_RD_LSB +: 5];
	wire [4:0] src_idx = cmd_r[`LSBX_CMD_SRC_LSB +: 5];
	wire [2:0] bit_r = cmd_r[`LSBX_CMD_BIT_LSB +: 3];
	wire is_prog = (op_r == lsbx_pkg::OP_PROGRAM_MEMORY_READ) || (op_r == lsbx_pkg::OP_EXTENDED_PROGRAM_READ)
		|| (op_r == lsbx_pkg::OP_PROGRAM_MEMORY_WRITE);
	wire [1:0] ptr_sel = (is_prog || cmd_r[`LSBX_CMD_PTR_LSB +: 2] == 2'h3) ? 2'h2 : cmd_r[`LSBX_CMD_PTR_LSB +: 2];
	wire [4:0] ptr_lo = 5'd26 + {2'b00, ptr_sel, 1'b0};
	wire [15:0] ptr_val = {gpr_r[ptr_lo | 5'd1], gpr_r[ptr_lo]};
	wire [15:0] z_val = {gpr_r[31], gpr_r[30]};
	wire [7:0] rd_val = gpr_r[rd_r];
	wire [7:0] src_val = gpr_r[src_idx];
	wire first = (state_r == lsbx_pkg::SEQ_EXEC) && (cyc_left_r == cyc_tot_r);
	wire last = (state_r == lsbx_pkg::SEQ_EXEC) && (cyc_left_r == 8'h01);

	// Incoming command, looked at before it is latched
	wire lsbx_pkg::lsbx_op_t in_op = lsbx_pkg::lsbx_op_t'(i_hwdata[`LSBX_CMD_OP_LSB +: 5]);
	wire lsbx_pkg::lsbx_mode_t in_mode = lsbx_pkg::lsbx_mode_t'(i_hwdata[`LSBX_CMD_MODE_LSB +: 2]);
	wire [1:0] in_sel = (i_hwdata[`LSBX_CMD_PTR_LSB +: 2] == 2'h3) ? 2'h2 : i_hwdata[`LSBX_CMD_PTR_LSB +: 2];
	wire [4:0] in_lo = 5'd26 + {2'b00, in_sel, 1'b0};
	wire [15:0] in_ptr = {gpr_r[in_lo | 5'd1], gpr_r[in_lo]};
	wire accept = bus_wr && (addr_r == `LSBX_OFF_CMD) && (state_r == lsbx_pkg::SEQ_IDLE);
	logic [15:0] acc_addr;
	logic [7:0] acc_cyc;
	logic acc_data, acc_sram, acc_ext;

	// Address and length of the incoming command
	always_comb
	begin
		acc_data = 1'b1;
		acc_cyc = `LSBX_CYC_SINGLE;
		acc_addr = in_ptr;
		case (in_op)
			lsbx_pkg::OP_INDIRECT_LOAD, lsbx_pkg::OP_INDIRECT_WRITE:
			begin
				if (in_mode == lsbx_pkg::MODE_PRE_DEC)
				begin
					acc_addr = in_ptr - 16'h0001;
					acc_cyc = `LSBX_CYC_PREDEC;
				end
				else if (in_mode == lsbx_pkg::MODE_DISP)
				begin
					acc_addr = in_ptr + arg_r;
					acc_cyc = `LSBX_CYC_DISP;
				end
			end
			lsbx_pkg::OP_DIRECT_DATA_WRITE:
			begin
				acc_addr = arg_r;
				acc_cyc = `LSBX_CYC_DIRECT;
			end
			lsbx_pkg::OP_PUSH:
				acc_addr = sp_r;
			lsbx_pkg::OP_POP:
			begin
				acc_addr = sp_r + 16'h0001;
				acc_cyc = `LSBX_CYC_POP;
			end
			lsbx_pkg::OP_PROGRAM_MEMORY_READ, lsbx_pkg::OP_EXTENDED_PROGRAM_READ:
			begin
				acc_data = 1'b0;
				acc_cyc = `LSBX_CYC_PROG;
			end
			lsbx_pkg::OP_PROGRAM_MEMORY_WRITE:
			begin
				acc_data = 1'b0;
				acc_cyc = `LSBX_CYC_PROG_WRITE;
			end
			default:
				acc_data = 1'b0;
		endcase
		acc_ext = acc_data && (acc_addr >= `LSBX_EXT_BASE);
		acc_sram = acc_data && !acc_ext && (acc_addr >= `LSBX_SRAM_BASE);
		if (acc_ext)
			acc_cyc = acc_cyc + 8'(EXT_WAIT);
		else if (acc_sram && in_op == lsbx_pkg::OP_INDIRECT_LOAD)
			acc_cyc = acc_cyc + `LSBX_CYC_SRAM_EXTRA;
	end

	// Address phase capture; only word writes are taken
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
		end
		else
		begin
			wr_pend_r <= addr_ok & i_hwrite & (i_hsize == 3'h2) & (i_haddr[31:8] == 24'h000000);
			rd_pend_r <= addr_ok & ~i_hwrite;
			if (addr_ok)
				addr_r <= i_haddr[7:0];
		end
	end

	// Read data mux; unmapped reads return zero
	always_comb
	begin
		rd_mux = 32'h00000000;
		if (addr_r[`LSBX_GPR_WINDOW_BIT])
			rd_mux = {24'h000000, gpr_r[addr_r[6:2]]};
		else
		begin
			case (addr_r)
				`LSBX_OFF_CMD: rd_mux = cmd_r;
				`LSBX_OFF_ARG: rd_mux = {16'h0000, arg_r};
				`LSBX_OFF_STAT: rd_mux = {16'h0000, last_cyc_r, 7'h00, busy_r};
				`LSBX_OFF_FLAGS: rd_mux = {24'h000000, flags_r};
				`LSBX_OFF_EXT: rd_mux = {24'h000000, ext_r};
				`LSBX_OFF_SP: rd_mux = {16'h0000, sp_r};
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// Reads take one wait state so read data comes from a flop
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			hreadyout_r <= 1'b1;
			hrdata_r <= 32'h00000000;
			hresp_r <= 1'b0;
		end
		else
		begin
			hreadyout_r <= ~(addr_ok & ~i_hwrite);
			if (rd_pend_r)
				hrdata_r <= rd_mux;
		end
	end

	// Sequencer
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			state_r <= lsbx_pkg::SEQ_IDLE;
			busy_r <= 1'b0;
			cmd_r <= 32'h00000000;
			cyc_left_r <= 8'h00;
			cyc_tot_r <= 8'h00;
			last_cyc_r <= 8'h00;
			sram_r <= 1'b0;
			xreg_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				lsbx_pkg::SEQ_IDLE:
					if (accept)
					begin
						state_r <= lsbx_pkg::SEQ_EXEC;
						busy_r <= 1'b1;
						cmd_r <= i_hwdata;
						cyc_left_r <= acc_cyc;
						cyc_tot_r <= acc_cyc;
						sram_r <= acc_sram;
						xreg_r <= acc_ext;
					end
				lsbx_pkg::SEQ_EXEC:
				begin
					cyc_left_r <= cyc_left_r - 8'h01;
					if (last)
					begin
						state_r <= lsbx_pkg::SEQ_IDLE;
						busy_r <= 1'b0;
						last_cyc_r <= cyc_tot_r;
					end
				end
			endcase
		end
	end

	logic [15:0] ea, ptr_nxt, sp_nxt;
	logic ptr_we, sp_we, gpr_we, flags_we;
	logic [4:0] gpr_idx;
	logic [7:0] gpr_wval, flags_nxt, alu_res, alu_flags;
	wire [7:0] bit_mask = 8'h01 << bit_r;

	lsbx_alu u_alu (
		.i_op(op_r),
		.i_val((op_r == lsbx_pkg::OP_BIT_TO_TRANSFER_FLAG) ? src_val : rd_val),
		.i_flags(flags_r),
		.i_bit(bit_r),
		.o_res(alu_res),
		.o_flags(alu_flags)
	);

	lsbx_mem #(.DDEPTH(DDEPTH), .PDEPTH(PDEPTH)) u_mem (
		.i_clock(i_clock),
		.mif(mif)
	);

	// Per-operation effects: pointer pre-adjust on first cycle, access on last
	always_comb
	begin
		ea = ptr_val;
		ptr_we = 1'b0;
		ptr_nxt = ptr_val;
		sp_we = 1'b0;
		sp_nxt = sp_r;
		gpr_we = 1'b0;
		gpr_idx = rd_r;
		gpr_wval = mif.d_rdata;
		flags_we = 1'b0;
		flags_nxt = flags_r;
		mif.d_we = 1'b0;
		mif.d_wdata = src_val;
		mif.io_we = 1'b0;
		mif.io_wdata = src_val;
		mif.io_addr = arg_r[5:0];
		mif.p_we = 1'b0;
		mif.p_wdata = {gpr_r[1], gpr_r[0]};
		mif.p_addr = {ext_r, z_val};
		case (op_r)
			lsbx_pkg::OP_INDIRECT_LOAD, lsbx_pkg::OP_INDIRECT_WRITE:
			begin
				if (mode_r == lsbx_pkg::MODE_DISP)
					ea = ptr_val + arg_r;
				if (first && mode_r == lsbx_pkg::MODE_PRE_DEC)
				begin
					ptr_we = 1'b1;
					ptr_nxt = ptr_val - 16'h0001;
				end
				if (last && mode_r == lsbx_pkg::MODE_POST_INC)
				begin
					ptr_we = 1'b1;
					ptr_nxt = ptr_val + 16'h0001;
				end
				gpr_we = last && (op_r == lsbx_pkg::OP_INDIRECT_LOAD);
				mif.d_we = last && (op_r == lsbx_pkg::OP_INDIRECT_WRITE);
			end
			lsbx_pkg::OP_DIRECT_DATA_WRITE:
			begin
				ea = arg_r;
				mif.d_we = last;
			end
			lsbx_pkg::OP_PROGRAM_MEMORY_READ, lsbx_pkg::OP_EXTENDED_PROGRAM_READ:
			begin
				if (op_r == lsbx_pkg::OP_PROGRAM_MEMORY_READ)
					mif.p_addr = {8'h00, z_val};
				gpr_we = last;
				gpr_idx = cmd_r[`LSBX_CMD_NOOPND_BIT] ? 5'd0 : rd_r;
				gpr_wval = mif.p_rdata;
				ptr_we = last && (mode_r == lsbx_pkg::MODE_POST_INC);
				ptr_nxt = ptr_val + 16'h0001;
			end
			lsbx_pkg::OP_PROGRAM_MEMORY_WRITE:
			begin
				mif.p_we = last;
				ptr_we = last && (mode_r == lsbx_pkg::MODE_POST_INC);
				ptr_nxt = ptr_val + 16'h0002;
			end
			lsbx_pkg::OP_IO_READ:
			begin
				gpr_we = last;
				gpr_wval = mif.io_rdata;
			end
			lsbx_pkg::OP_IO_WRITE:
				mif.io_we = last;
			lsbx_pkg::OP_IO_BIT_SET, lsbx_pkg::OP_IO_BIT_CLEAR:
			begin
				mif.io_we = last;
				mif.io_wdata = (op_r == lsbx_pkg::OP_IO_BIT_SET) ? (mif.io_rdata | bit_mask)
					: (mif.io_rdata & ~bit_mask);
			end
			lsbx_pkg::OP_PUSH:
			begin
				ea = sp_r;
				mif.d_we = last;
				sp_we = last;
				sp_nxt = sp_r - 16'h0001;
			end
			lsbx_pkg::OP_POP:
			begin
				ea = sp_r;
				sp_we = first;
				sp_nxt = sp_r + 16'h0001;
				gpr_we = last;
			end
			lsbx_pkg::OP_SHIFT_LEFT_LOGICAL, lsbx_pkg::OP_SHIFT_RIGHT_LOGICAL, lsbx_pkg::OP_SHIFT_RIGHT_ARITH,
			lsbx_pkg::OP_ROTATE_LEFT_CARRY, lsbx_pkg::OP_ROTATE_RIGHT_CARRY, lsbx_pkg::OP_TRANSFER_FLAG_TO_BIT:
			begin
				gpr_we = last;
				gpr_wval = alu_res;
				flags_we = last;
				flags_nxt = alu_flags;
			end
			lsbx_pkg::OP_BIT_TO_TRANSFER_FLAG:
			begin
				flags_we = last;
				flags_nxt = alu_flags;
			end
			lsbx_pkg::OP_FLAG_SET, lsbx_pkg::OP_FLAG_CLEAR:
			begin
				flags_we = last;
				flags_nxt[bit_r] = (op_r == lsbx_pkg::OP_FLAG_SET);
			end
			default:
				ea = ptr_val;
		endcase
		mif.d_addr = ea;
	end

	// Working registers; execution wins over a bus write
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < 32; i++)
				gpr_r[i] <= 8'h00;
		end
		else
		begin
			if (bus_wr && addr_r[`LSBX_GPR_WINDOW_BIT])
				gpr_r[addr_r[6:2]] <= i_hwdata[7:0];
			if (ptr_we)
			begin
				gpr_r[ptr_lo] <= ptr_nxt[7:0];
				gpr_r[ptr_lo | 5'd1] <= ptr_nxt[15:8];
			end
			if (gpr_we)
				gpr_r[gpr_idx] <= gpr_wval;
		end
	end

	// Flags, extension byte, stack pointer, argument
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			flags_r <= `LSBX_RST_FLAGS;
			ext_r <= `LSBX_RST_EXT;
			sp_r <= `LSBX_RST_SP;
			arg_r <= 16'h0000;
		end
		else
		begin
			if (bus_wr && addr_r == `LSBX_OFF_FLAGS)
				flags_r <= i_hwdata[7:0];
			if (flags_we)
				flags_r <= flags_nxt;
			if (bus_wr && addr_r == `LSBX_OFF_EXT)
				ext_r <= i_hwdata[7:0];
			if (bus_wr && addr_r == `LSBX_OFF_SP)
				sp_r <= i_hwdata[15:0];
			if (sp_we)
				sp_r <= sp_nxt;
			if (bus_wr && addr_r == `LSBX_OFF_ARG)
				arg_r <= i_hwdata[15:0];
		end
	end

	assign o_hrdata = hrdata_r;
	assign o_hreadyout = hreadyout_r;
	assign o_hresp = hresp_r;
	assign o_busy = busy_r;

	// Checks on execution behaviour
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	property p_predec_load;
		first && op_r == lsbx_pkg::OP_INDIRECT_LOAD && mode_r == lsbx_pkg::MODE_PRE_DEC && !sram_r && !xreg_r
			|-> cyc_tot_r == 8'h02 ##1 ptr_val == $past(ptr_val) - 16'h0001;
	endproperty
	a_predec_load: assert property (p_predec_load) else $error("pre-decrement load timing or pointer wrong");

	property p_postinc_load;
		first && op_r == lsbx_pkg::OP_INDIRECT_LOAD && mode_r == lsbx_pkg::MODE_POST_INC && !sram_r && !xreg_r
			&& rd_r[4:1] != ptr_lo[4:1] |-> last ##1 ptr_val == $past(ptr_val) + 16'h0001;
	endproperty
	a_postinc_load: assert property (p_postinc_load) else $error("post-increment load wrong");

	property p_disp_keep;
		first && mode_r == lsbx_pkg::MODE_DISP && op_r == lsbx_pkg::OP_INDIRECT_WRITE && !xreg_r
			|-> cyc_tot_r == 8'h02 ##1 (last && ptr_val == $past(ptr_val)) ##1 ptr_val == $past(ptr_val, 2);
	endproperty
	a_disp_keep: assert property (p_disp_keep) else $error("displaced write moved pointer");

	property p_direct_two;
		first && op_r == lsbx_pkg::OP_DIRECT_DATA_WRITE && !xreg_r |-> !mif.d_we ##1 mif.d_we && last;
	endproperty
	a_direct_two: assert property (p_direct_two) else $error("direct write not in second cycle");

	property p_prog_three;
		accept && (in_op == lsbx_pkg::OP_PROGRAM_MEMORY_READ || in_op == lsbx_pkg::OP_EXTENDED_PROGRAM_READ)
			|=> busy_r [*3] ##1 !busy_r;
	endproperty
	a_prog_three: assert property (p_prog_three) else $error("program read not three cycles");

	property p_prog_addr;
		first && (op_r == lsbx_pkg::OP_PROGRAM_MEMORY_READ || op_r == lsbx_pkg::OP_EXTENDED_PROGRAM_READ)
			|-> mif.p_addr == {((op_r == lsbx_pkg::OP_EXTENDED_PROGRAM_READ) ? ext_r : 8'h00), z_val};
	endproperty
	a_prog_addr: assert property (p_prog_addr) else $error("program read address wrong");

	property p_push_pop;
		first && !xreg_r && (op_r == lsbx_pkg::OP_PUSH || op_r == lsbx_pkg::OP_POP)
			|-> cyc_tot_r == ((op_r == lsbx_pkg::OP_PUSH) ? 8'h01 : 8'h02);
	endproperty
	a_push_pop: assert property (p_push_pop) else $error("push or pop length wrong");

	property p_rol_carry;
		last && op_r == lsbx_pkg::OP_ROTATE_LEFT_CARRY
			|=> flags_r[`LSBX_FLAG_C] == $past(rd_val[7]) && flags_r[`LSBX_FLAG_H] == $past(rd_val[3]);
	endproperty
	a_rol_carry: assert property (p_rol_carry) else $error("rotate left carry flags wrong");

	property p_bst_only_t;
		last && op_r == lsbx_pkg::OP_BIT_TO_TRANSFER_FLAG |=> ((flags_r ^ $past(flags_r)) & 8'hbf) == 8'h00;
	endproperty
	a_bst_only_t: assert property (p_bst_only_t) else $error("bit to flag changed another flag");

	property p_io_bit_flags;
		first && (op_r == lsbx_pkg::OP_IO_BIT_SET || op_r == lsbx_pkg::OP_IO_BIT_CLEAR)
			|-> mif.io_we ##1 !busy_r && flags_r == $past(flags_r);
	endproperty
	a_io_bit_flags: assert property (p_io_bit_flags) else $error("I/O bit operation wrong");

	property p_flag_set;
		last && op_r == lsbx_pkg::OP_FLAG_SET |=> flags_r[$past(bit_r)];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag set did not set");

	property p_sram_extra;
		first && op_r == lsbx_pkg::OP_INDIRECT_LOAD && sram_r && mode_r != lsbx_pkg::MODE_PRE_DEC
			&& mode_r != lsbx_pkg::MODE_DISP |-> cyc_tot_r == 8'h02;
	endproperty
	a_sram_extra: assert property (p_sram_extra) else $error("SRAM load lacks extra cycle");
endmodule

// ---- verification/lsbx_core_bench.sv ----
module lsbx_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EW = 3;
	logic clk;
	logic rst;
	logic sel;
	logic [31:0] addr;
	logic [1:0] tr;
	logic wr;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic rdy;
	logic resp;
	logic busy;
	logic [31:0] q;
	int failures;
	int compares;

	// Device under test, bus ready looped back
	lsbx_core #(.EXT_WAIT(EW)) i_dut (.i_clock(clk), .i_srst(rst), .i_hsel(sel), .i_haddr(addr),
		.i_htrans(tr), .i_hwrite(wr), .i_hsize(3'h2), .i_hwdata(wd), .i_hready(rdy),
		.o_hrdata(rdat), .o_hreadyout(rdy), .o_hresp(resp), .o_busy(busy));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic summarize;
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// One single word transfer; address phase held until ready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		addr <= {24'h000000, a};
		wr <= w;
		tr <= 2'h2;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rdy !== 1'b1 && n < 40);
		tr <= 2'h0;
		wd <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rdy !== 1'b1 && n < 40);
		q = rdat;
		if (n >= 40)
		begin
			failures++;
			summarize();
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
		chk({31'h0, resp}, 32'h0);
	endtask

	task automatic g(input int n, input logic [7:0] v);
		bus(1'b1, 8'h80 + 8'(4 * n), {24'h0, v});
	endtask

	task automatic gr(input int n, input logic [7:0] e);
		rc(8'h80 + 8'(4 * n), {24'h0, e});
	endtask

	// Issue a command and compare its cycle count
	task automatic run(input logic [4:0] op, input logic [1:0] m, input logic [3:0] p, input logic [4:0] d,
		input logic [4:0] r, input logic [2:0] b, input logic [15:0] arg, input logic [7:0] cyc);
		int n;
		bus(1'b1, 8'h04, {16'h0, arg});
		bus(1'b1, 8'h00, {b, r, 3'h0, d, p, 2'h0, m, 3'h0, op});
		// Busy pin raised at the edge that took the command
		@(posedge clk);
		chk({31'h0, busy}, 32'h1);
		n = 0;
		do
		begin
			bus(1'b0, 8'h08, 32'h0);
			n++;
		end
		while (q[0] !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			failures++;
			summarize();
		end
		chk({24'h0, q[15:8]}, {24'h0, cyc});
		chk({31'h0, busy}, 32'h0);
	endtask

	// Shift or rotate with given carry in
	task automatic sh(input logic [4:0] op, input logic [7:0] v, input logic [7:0] fi, input logic [7:0] res,
		input logic [7:0] fo);
		g(8, v);
		bus(1'b1, 8'h0c, {24'h0, fi});
		run(op, 2'h0, 4'h0, 5'd8, 5'd0, 3'h0, 16'h0, 8'h01);
		gr(8, res);
		rc(8'h0c, {24'h0, fo});
	endtask

	// Main sequence
	initial
	begin
		rst = 1'b1;
		sel = 1'b1;
		addr = 32'h0;
		tr = 2'h0;
		wr = 1'b0;
		wd = 32'h0;
		failures = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(8'h0c, 32'h0);
		rc(8'h14, 32'h00ff);
		rc(8'h10, 32'h0);
		rc(8'h40, 32'h0);
		g(26, 8'h10);
		g(27, 8'h00);
		g(3, 8'ha5);
		run(5'd2, 2'h1, 4'h0, 5'd0, 5'd3, 3'h0, 16'h0, 8'h01);
		gr(26, 8'h11);
		run(5'd1, 2'h2, 4'h0, 5'd4, 5'd0, 3'h0, 16'h0, 8'h02);
		gr(26, 8'h10);
		gr(4, 8'ha5);
		run(5'd1, 2'h1, 4'h0, 5'd5, 5'd0, 3'h0, 16'h0, 8'h01);
		gr(5, 8'ha5);
		gr(26, 8'h11);
		g(28, 8'h20);
		g(29, 8'h00);
		g(3, 8'h5a);
		run(5'd2, 2'h3, 4'h1, 5'd0, 5'd3, 3'h0, 16'h3, 8'h02);
		gr(28, 8'h20);
		g(30, 8'h20);
		g(31, 8'h00);
		run(5'd1, 2'h3, 4'h2, 5'd6, 5'd0, 3'h0, 16'h3, 8'h02);
		gr(6, 8'h5a);
		gr(30, 8'h20);
		run(5'd2, 2'h2, 4'h2, 5'd0, 5'd3, 3'h0, 16'h0, 8'h02);
		gr(30, 8'h1f);
		run(5'd1, 2'h0, 4'h2, 5'd9, 5'd0, 3'h0, 16'h0, 8'h01);
		gr(9, 8'h5a);
		g(3, 8'h3c);
		run(5'd3, 2'h0, 4'h0, 5'd0, 5'd3, 3'h0, 16'h0030, 8'h02);
		g(26, 8'h30);
		run(5'd1, 2'h0, 4'h0, 5'd7, 5'd0, 3'h0, 16'h0, 8'h01);
		gr(7, 8'h3c);
		g(27, 8'h20);
		run(5'd1, 2'h0, 4'h0, 5'd8, 5'd0, 3'h0, 16'h0, 8'h02);
		gr(8, 8'h3c);
		g(27, 8'h40);
		run(5'd2, 2'h0, 4'h0, 5'd0, 5'd3, 3'h0, 16'h0, 8'(1 + EW));
		g(0, 8'h34);
		g(1, 8'h12);
		g(30, 8'h04);
		g(31, 8'h00);
		run(5'd6, 2'h1, 4'h2, 5'd0, 5'd0, 3'h0, 16'h0, 8'h01);
		gr(30, 8'h06);
		g(30, 8'h04);
		run(5'd4, 2'h0, 4'h2, 5'd10, 5'd0, 3'h0, 16'h0, 8'h03);
		gr(10, 8'h34);
		g(30, 8'h05);
		run(5'd4, 2'h1, 4'ha, 5'd11, 5'd0, 3'h0, 16'h0, 8'h03);
		gr(0, 8'h12);
		gr(30, 8'h06);
		g(30, 8'h04);
		bus(1'b1, 8'h10, 32'h5);
		rc(8'h10, 32'h5);
		run(5'd5, 2'h0, 4'h2, 5'd12, 5'd0, 3'h0, 16'h0, 8'h03);
		gr(12, 8'h34);
		g(3, 8'ha5);
		run(5'd8, 2'h0, 4'h0, 5'd0, 5'd3, 3'h0, 16'h5, 8'h01);
		run(5'd18, 2'h0, 4'h0, 5'd0, 5'd0, 3'h1, 16'h5, 8'h01);
		run(5'd19, 2'h0, 4'h0, 5'd0, 5'd0, 3'h0, 16'h5, 8'h01);
		run(5'd7, 2'h0, 4'h0, 5'd13, 5'd0, 3'h0, 16'h5, 8'h01);
		gr(13, 8'ha6);
		rc(8'h0c, 32'h0);
		run(5'd9, 2'h0, 4'h0, 5'd0, 5'd3, 3'h0, 16'h0, 8'h01);
		rc(8'h14, 32'h00fe);
		run(5'd10, 2'h0, 4'h0, 5'd14, 5'd0, 3'h0, 16'h0, 8'h02);
		gr(14, 8'ha5);
		rc(8'h14, 32'h00ff);
		sh(5'd14, 8'h88, 8'h01, 8'h11, 8'h29);
		sh(5'd15, 8'h02, 8'h01, 8'h81, 8'h0c);
		sh(5'd11, 8'h80, 8'h01, 8'h00, 8'h0b);
		sh(5'd12, 8'h81, 8'h00, 8'h40, 8'h09);
		sh(5'd13, 8'h81, 8'h00, 8'hc0, 8'h05);
		bus(1'b1, 8'h0c, 32'h1);
		g(9, 8'h04);
		run(5'd16, 2'h0, 4'h0, 5'd0, 5'd9, 3'h2, 16'h0, 8'h01);
		rc(8'h0c, 32'h41);
		g(10, 8'h00);
		run(5'd17, 2'h0, 4'h0, 5'd10, 5'd0, 3'h7, 16'h0, 8'h01);
		gr(10, 8'h80);
		rc(8'h0c, 32'h41);
		bus(1'b1, 8'h0c, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			run(5'd20, 2'h0, 4'h0, 5'd0, 5'd0, 3'(i), 16'h0, 8'h01);
			rc(8'h0c, 32'h1 << i);
			run(5'd21, 2'h0, 4'h0, 5'd0, 5'd0, 3'(i), 16'h0, 8'h01);
			rc(8'h0c, 32'h0);
		end
		summarize();
	end
endmodule
